// ===== rtl/hv_meas_pkg.sv
// Shared constants and types for the measure path control block
package hv_meas_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PULL   = 8'h04;
    localparam logic [7:0] OFS_WCTL1  = 8'h08;
    localparam logic [7:0] OFS_IRQST  = 8'h0C;
    localparam logic [7:0] OFS_IRQMSK = 8'h10;
    localparam logic [7:0] OFS_LEVEL  = 8'h14;

    // ------------------------------------------------------------
    // Field widths and reset values
    // ------------------------------------------------------------
    localparam int         CTRL_W    = 7;
    localparam int         PULL_W    = 4;
    localparam int         WCTL1_W   = 2;
    localparam int         ST_W      = 3;
    localparam int         ST_ERR    = 0;
    localparam int         ST_SENSE  = 1;
    localparam int         ST_PIN    = 2;
    localparam logic [6:0] CTRL_RST  = 7'h00;
    localparam logic [3:0] PULL_RST  = 4'h0;
    localparam logic [1:0] WCTL1_RST = 2'h0;
    localparam logic [2:0] MASK_RST  = 3'h0;

    // Device operating modes, driven by the mode controller
    typedef enum logic [2:0] {
        MODE_NORMAL   = 3'b000,
        MODE_STOP     = 3'b001,
        MODE_SLEEP    = 3'b010,
        MODE_RESTART  = 3'b011,
        MODE_FAILSAFE = 3'b100
    } mode_t;

    // Function of the multipurpose pin
    typedef enum logic [2:0] {
        PIN_OFF       = 3'b000,
        PIN_FAIL      = 3'b001,
        PIN_WAKE      = 3'b010,
        PIN_LOWSIDE   = 3'b011,
        PIN_HIGHSIDE  = 3'b100
    } pincfg_t;

    // Control register layout, bit 6 downward
    typedef struct packed {
        logic    gpioOn;
        logic    testDrive;
        pincfg_t pinCfg;
        logic    senseWakeEn;
        logic    measEn;
    } ctrl_t;

    // Pull current enables for both pins
    typedef struct packed {
        logic pinUp;
        logic pinDn;
        logic senseUp;
        logic senseDn;
    } pull_t;

endpackage : hv_meas_pkg

// ===== rtl/pin_sync.sv
// Three stage synchroniser with agreement based change detection
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Asynchronous pin level
    input  wire logic pinIn,
    // Settled level and one cycle change pulse
    output logic      level,
    output logic      changed
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic changed;
    } sync_t;

    sync_t s_reg;
    sync_t s_next;

    // A change only counts once stages two and three agree
    always_comb begin
        s_next         = s_reg;
        s_next.s1      = pinIn;
        s_next.s2      = s_reg.s1;
        s_next.s3      = s_reg.s2;
        s_next.changed = (s_reg.s2 == s_reg.s3) &&
                         (s_reg.s3 != s_reg.level);
        if (s_reg.s2 == s_reg.s3) begin
            s_next.level = s_reg.s3;
        end
    end

    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level   = s_reg.level;
    assign changed = s_reg.changed;

endmodule : pin_sync

// ===== rtl/wake_irq.sv
// Sticky event status, mask and level interrupt output
`timescale 1ns/1ps
module wake_irq (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        nrst,
    // Event set and write-one-to-clear
    input  wire logic [hv_meas_pkg::ST_W-1:0] setEv,
    input  wire logic [hv_meas_pkg::ST_W-1:0] clrW1c,
    // Mask write
    input  wire logic                        maskWe,
    input  wire logic [hv_meas_pkg::ST_W-1:0] maskIn,
    // State seen by software and the system
    output logic      [hv_meas_pkg::ST_W-1:0] status,
    output logic      [hv_meas_pkg::ST_W-1:0] mask,
    output logic                             irq
);

    typedef struct packed {
        logic [hv_meas_pkg::ST_W-1:0] status;
        logic [hv_meas_pkg::ST_W-1:0] mask;
        logic                         irq;
    } irq_t;

    irq_t s_reg;
    irq_t s_next;

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        s_next        = s_reg;
        s_next.status = (s_reg.status & ~clrW1c) | setEv;
        if (maskWe) begin
            s_next.mask = maskIn;
        end
        s_next.irq    = |(s_next.status & s_next.mask);
    end

    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg <= {{hv_meas_pkg::ST_W{1'b0}},
                      hv_meas_pkg::MASK_RST, 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign status = s_reg.status;
    assign mask   = s_reg.mask;
    assign irq    = s_reg.irq;

endmodule : wake_irq

// ===== rtl/hv_measure_path_control.sv
// High voltage measure path control with Wishbone registers
//
// Contract
// RULE1 - Measuring routes sense input to multipurpose pin
// RULE2 - Reset leaves measurement off, switch open
// RULE3 - Enable bit closes switch only in Normal
// RULE4 - Other modes open switch, keep stored enable
// RULE5 - Measuring kills pulls and gates pin signals
// RULE6 - Pull, wake control, pin config ignored, stored (a pin config change is not stored, see RULE7)
// RULE7 - Pin config change while measuring flags error
// RULE8 - Measuring freezes wake status and level registers
// RULE9 - Wake enables writable but ignored while measuring
// RULE10 - Sleep with pin-only wakes: error, go Restart
// RULE11 - Measuring disables fail output, GPIO, pin wake
// RULE12 - Enable refused with error unless pin Off
// RULE13 - Fail-Safe unmeasured: sense wake auto, pin wake
// RULE14 - Switch follows enable and mode every clock
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module hv_measure_path_control (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                nrst,
    // Wishbone classic slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Mode controller
    input  wire hv_meas_pkg::mode_t  devMode,
    input  wire logic                sleepCmd,
    input  wire logic                otherWakeSrc,
    output logic                     sleepGrant,
    output logic                     restartReq,
    output logic      [1:0]          wakeEvents,
    // Pins
    input  wire logic                hvSenseIn,
    input  wire logic                pinIn,
    output logic                     pinOut,
    output logic                     pinOe,
    // Analogue controls and gated levels
    output logic                     measSwitchClose,
    output hv_meas_pkg::pull_t       pulls,
    output logic      [1:0]          gatedLevels,
    // Interrupt
    output logic                     irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        hv_meas_pkg::ctrl_t ctrl;
        logic [3:0]         pull;
        logic [1:0]         wctl1;
        logic [1:0]         level;
        logic               ack;
        logic [31:0]        rdata;
        logic               sw;
        hv_meas_pkg::pull_t pulls;
        logic [1:0]         gated;
        logic               pinOut;
        logic               pinOe;
        logic               sleepGrant;
        logic               restartReq;
        logic [1:0]         wake;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic                         senseLvl;
    logic                         senseChg;
    logic                         pinLvl;
    logic                         pinChg;
    logic [hv_meas_pkg::ST_W-1:0] stSet;
    logic [hv_meas_pkg::ST_W-1:0] stClr;
    logic [hv_meas_pkg::ST_W-1:0] stStatus;
    logic [hv_meas_pkg::ST_W-1:0] stMask;
    logic                         maskWe;
    logic                         reqEdge;
    logic                         commit;
    logic                         errSet;
    hv_meas_pkg::ctrl_t           wrCtrl;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pin_sync u_sense_sync (
        .clock   (clock),
        .nrst    (nrst),
        .pinIn   (hvSenseIn),
        .level   (senseLvl),
        .changed (senseChg)
    );

    pin_sync u_pin_sync (
        .clock   (clock),
        .nrst    (nrst),
        .pinIn   (pinIn),
        .level   (pinLvl),
        .changed (pinChg)
    );

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    wake_irq u_irq (
        .clock  (clock),
        .nrst   (nrst),
        .setEv  (stSet),
        .clrW1c (stClr),
        .maskWe (maskWe),
        .maskIn (wb_dat_i[hv_meas_pkg::ST_W-1:0]),
        .status (stStatus),
        .mask   (stMask),
        .irq    (irq)
    );

    // Bus qualifiers; writes land on the acknowledging edge
    assign reqEdge = wb_cyc_i && wb_stb_i && !s_reg.ack;
    assign commit  = wb_cyc_i && wb_stb_i && s_reg.ack &&
                     wb_we_i && wb_sel_i[0];
    assign wrCtrl  = hv_meas_pkg::ctrl_t'(
                         wb_dat_i[hv_meas_pkg::CTRL_W-1:0]);
    assign maskWe  = commit && (wb_adr_i == hv_meas_pkg::OFS_IRQMSK);
    assign stClr   = (commit && wb_adr_i == hv_meas_pkg::OFS_IRQST)
                   ? wb_dat_i[hv_meas_pkg::ST_W-1:0]
                   : '0;
    assign stSet   = {s_next.wake, errSet};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next            = s_reg;
        errSet            = 1'b0;
        s_next.ack        = reqEdge;
        s_next.sleepGrant = 1'b0;
        s_next.restartReq = 1'b0;
        s_next.wake       = 2'b00;

        // Read data captured on the request edge, unmapped reads zero
        if (reqEdge) begin
            s_next.rdata = '0;
            case (wb_adr_i)
                hv_meas_pkg::OFS_CTRL:
                    s_next.rdata[6:0] = s_reg.ctrl;
                hv_meas_pkg::OFS_PULL:
                    s_next.rdata[3:0] = s_reg.pull;
                hv_meas_pkg::OFS_WCTL1:
                    s_next.rdata[1:0] = s_reg.wctl1;
                hv_meas_pkg::OFS_IRQST:
                    s_next.rdata[2:0] = stStatus;
                hv_meas_pkg::OFS_IRQMSK:
                    s_next.rdata[2:0] = stMask;
                hv_meas_pkg::OFS_LEVEL:
                    s_next.rdata[1:0] = s_reg.level;
                default:
                    s_next.rdata = '0;
            endcase
        end

        // Register writes; pull and wake control always stored
        if (commit) begin
            case (wb_adr_i)
                hv_meas_pkg::OFS_CTRL: begin
                    // Wake enable is stored even while measuring
                    s_next.ctrl.senseWakeEn = wrCtrl.senseWakeEn; // see RULE9
                    s_next.ctrl.testDrive   = wrCtrl.testDrive;
                    s_next.ctrl.gpioOn      = wrCtrl.gpioOn;
                    if (s_reg.ctrl.measEn &&
                        wrCtrl.pinCfg != s_reg.ctrl.pinCfg) begin
                        errSet = 1'b1;                      // see RULE7
                    end else begin
                        s_next.ctrl.pinCfg = wrCtrl.pinCfg;
                    end
                    // Enable only from a pin that is, and stays, Off
                    if (wrCtrl.measEn && !s_reg.ctrl.measEn &&
                        (s_reg.ctrl.pinCfg != hv_meas_pkg::PIN_OFF ||
                         wrCtrl.pinCfg != hv_meas_pkg::PIN_OFF)) begin
                        errSet = 1'b1;                     // see RULE12
                    end else begin
                        s_next.ctrl.measEn = wrCtrl.measEn;
                    end
                end
                hv_meas_pkg::OFS_PULL:
                    s_next.pull = wb_dat_i[3:0];            // see RULE6
                hv_meas_pkg::OFS_WCTL1:
                    s_next.wctl1 = wb_dat_i[1:0];           // see RULE6
                default: begin
                    s_next.pull = s_next.pull;
                end
            endcase
        end

        // Sleep refused when only pin wakes remain usable
        if (sleepCmd) begin
            if (s_reg.ctrl.measEn && !otherWakeSrc &&
                (s_reg.ctrl.senseWakeEn ||
                 s_reg.ctrl.pinCfg == hv_meas_pkg::PIN_WAKE)) begin
                errSet            = 1'b1;                  // see RULE10
                s_next.restartReq = 1'b1;                  // see RULE10
            end else begin
                s_next.sleepGrant = 1'b1;
            end
        end

        // Wake and level processing, frozen while measuring
        if (!s_reg.ctrl.measEn) begin                       // see RULE8
            s_next.level   = {pinLvl, senseLvl};
            // Fail-Safe arms the sense input regardless of enable
            s_next.wake[0] = senseChg &&
                (s_reg.ctrl.senseWakeEn ||
                 devMode == hv_meas_pkg::MODE_FAILSAFE) &&  // see RULE13
                (!s_reg.wctl1[0] || senseLvl);
            s_next.wake[1] = pinChg &&
                s_reg.ctrl.pinCfg == hv_meas_pkg::PIN_WAKE &&
                (!s_reg.wctl1[1] || pinLvl);
        end

        // Switch recomputed on every edge from enable and mode
        s_next.sw = s_next.ctrl.measEn &&
                    devMode == hv_meas_pkg::MODE_NORMAL; // see RULE3 RULE14

        // Pulls and gated levels follow the updated enable
        if (s_next.ctrl.measEn) begin
            s_next.pulls = '0;                              // see RULE5
            s_next.gated = 2'b00;                           // see RULE5
        end else begin
            s_next.pulls = hv_meas_pkg::pull_t'(s_next.pull);
            s_next.gated = {pinLvl, senseLvl};
        end

        // Pin driver; fail output is active low open drain
        s_next.pinOut = 1'b0;
        s_next.pinOe  = 1'b0;
        if (!s_next.ctrl.measEn) begin                     // see RULE11
            case (s_next.ctrl.pinCfg)
                hv_meas_pkg::PIN_FAIL:
                    s_next.pinOe = s_next.ctrl.testDrive ||
                        devMode == hv_meas_pkg::MODE_FAILSAFE;
                hv_meas_pkg::PIN_LOWSIDE:
                    s_next.pinOe = s_next.ctrl.gpioOn;
                hv_meas_pkg::PIN_HIGHSIDE: begin
                    s_next.pinOe  = s_next.ctrl.gpioOn;
                    s_next.pinOut = s_next.ctrl.gpioOn;
                end
                default:
                    s_next.pinOe = 1'b0;
            endcase
        end
    end

    // State register; everything comes out of reset disabled
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg       <= '0;                              // see RULE2
            s_reg.ctrl  <= hv_meas_pkg::CTRL_RST;
            s_reg.pull  <= hv_meas_pkg::PULL_RST;
            s_reg.wctl1 <= hv_meas_pkg::WCTL1_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o        = s_reg.rdata;
    assign wb_ack_o        = s_reg.ack;
    assign sleepGrant      = s_reg.sleepGrant;
    assign restartReq      = s_reg.restartReq;
    assign wakeEvents      = s_reg.wake;
    assign pinOut          = s_reg.pinOut;
    assign pinOe           = s_reg.pinOe;
    assign measSwitchClose = s_reg.sw;                      // see RULE1
    assign pulls           = s_reg.pulls;
    assign gatedLevels     = s_reg.gated;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    property p_sw_follows;
        measSwitchClose == (s_reg.ctrl.measEn &&
            $past(devMode) == hv_meas_pkg::MODE_NORMAL);
    endproperty
    a_sw_follows: assert property (p_sw_follows) // see RULE14
        else $error("switch does not follow enable and mode");

    property p_sw_open;
        devMode != hv_meas_pkg::MODE_NORMAL |=> !measSwitchClose;
    endproperty
    a_sw_open: assert property (p_sw_open) // see RULE4
        else $error("switch closed outside Normal mode");

    property p_keep_en;
        devMode != hv_meas_pkg::MODE_NORMAL && !commit
            |=> s_reg.ctrl.measEn == $past(s_reg.ctrl.measEn);
    endproperty
    a_keep_en: assert property (p_keep_en) // see RULE4
        else $error("enable lost on mode change");

    property p_pull_off;
        s_reg.ctrl.measEn |-> pulls == '0 && gatedLevels == 2'b00;
    endproperty
    a_pull_off: assert property (p_pull_off) // see RULE5
        else $error("pulls or levels active while measuring");

    property p_freeze;
        s_reg.ctrl.measEn |=> $stable(s_reg.level) && wakeEvents == 0;
    endproperty
    a_freeze: assert property (p_freeze) // see RULE8
        else $error("wake state updated while measuring");

    property p_cfg_err;
        commit && wb_adr_i == hv_meas_pkg::OFS_CTRL &&
        s_reg.ctrl.measEn && wrCtrl.pinCfg != s_reg.ctrl.pinCfg
            |=> stStatus[hv_meas_pkg::ST_ERR] && $stable(s_reg.ctrl.pinCfg);
    endproperty
    a_cfg_err: assert property (p_cfg_err) // see RULE7
        else $error("pin config change not flagged");

    property p_refuse;
        commit && wb_adr_i == hv_meas_pkg::OFS_CTRL && wrCtrl.measEn &&
        !s_reg.ctrl.measEn && s_reg.ctrl.pinCfg != hv_meas_pkg::PIN_OFF
            |=> !s_reg.ctrl.measEn && stStatus[hv_meas_pkg::ST_ERR];
    endproperty
    a_refuse: assert property (p_refuse) // see RULE12
        else $error("enable accepted with pin not Off");

    property p_sleep_restart;
        sleepCmd && s_reg.ctrl.measEn && !otherWakeSrc &&
        s_reg.ctrl.senseWakeEn
            |=> restartReq && !sleepGrant ##1 (!restartReq || $past(sleepCmd));
    endproperty
    a_sleep_restart: assert property (p_sleep_restart) // see RULE10
        else $error("sleep not turned into restart");

    property p_no_drive;
        s_reg.ctrl.measEn |-> !pinOe;
    endproperty
    a_no_drive: assert property (p_no_drive) // see RULE11
        else $error("pin driven while measuring");

    property p_fs_wake;
        devMode == hv_meas_pkg::MODE_FAILSAFE && !s_reg.ctrl.measEn &&
        senseChg && !s_reg.wctl1[0] |=> wakeEvents[0];
    endproperty
    a_fs_wake: assert property (p_fs_wake) // see RULE13
        else $error("no sense wake in Fail-Safe");

    c_meas_on: cover property (measSwitchClose ##1 !measSwitchClose);
    c_refused: cover property (commit ##1 stStatus[hv_meas_pkg::ST_ERR]);
    c_restart: cover property (restartReq);
    c_wake:    cover property (wakeEvents[1] ##[1:4] irq);

endmodule : hv_measure_path_control

// ===== dv/adc_divider_model.sv
// Divider and converter model on the multipurpose pin
`timescale 1ns/1ps
module adc_divider_model (
    // Clock
    input  wire logic               clock,
    // Pin drivers and analogue controls
    input  wire logic               hvSense,
    input  wire logic               pinOut,
    input  wire logic               pinOe,
    input  wire logic               switchClose,
    input  wire hv_meas_pkg::pull_t pulls,
    // Wire level and converter result
    output logic                    pinLevel,
    output logic      [7:0]         adcCode
);
    logic floatBit = 1'b0;

    // Undriven pin wanders, so the sim never settles it kindly
    always_ff @(posedge clock) begin
        floatBit <= ~floatBit;
    end

    // Resolve the wire from all parties
    always_comb begin
        if (switchClose) begin
            pinLevel = hvSense;
        end else if (pinOe) begin
            pinLevel = pinOut;
        end else if (pulls.pinUp | pulls.pinDn) begin
            pinLevel = pulls.pinUp;
        end else begin
            pinLevel = floatBit;
        end
        // Divider only carries current with the switch closed
        adcCode = switchClose ? {8{hvSense}} : 8'h00;
    end
endmodule : adc_divider_model

// ===== dv/tb_hv_measure_path_control.sv
// Self-checking bench for the measure path control block
`timescale 1ns/1ps
module tb_hv_measure_path_control;
    logic clock = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] datI = 32'h0, datO, rd;
    logic ack, sleepCmd = 1'b0, otherWake = 1'b0, hvSense = 1'b0;
    logic pinLevel, pinOut, pinOe, swClose, sGrant, rReq, irq;
    logic [1:0] wakeEv, gated;
    logic [7:0] adcCode;
    hv_meas_pkg::mode_t devMode = hv_meas_pkg::MODE_NORMAL;
    hv_meas_pkg::pull_t pulls;
    int fails = 0, nTests = 0;

    always #20 clock = ~clock;

    hv_measure_path_control u_hv_measure_path_control (.clock(clock),
        .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
        .wb_ack_o(ack), .devMode(devMode), .sleepCmd(sleepCmd),
        .otherWakeSrc(otherWake), .sleepGrant(sGrant), .restartReq(rReq),
        .wakeEvents(wakeEv), .hvSenseIn(hvSense), .pinIn(pinLevel),
        .pinOut(pinOut), .pinOe(pinOe), .measSwitchClose(swClose),
        .pulls(pulls), .gatedLevels(gated), .irq(irq));

    adc_divider_model u_adc_divider_model (.clock(clock),
        .hvSense(hvSense), .pinOut(pinOut), .pinOe(pinOe),
        .switchClose(swClose), .pulls(pulls), .pinLevel(pinLevel),
        .adcCode(adcCode));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        nTests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h", $time, m, got);
        end
    endtask : chk

    // One classic cycle, held until ack; only the watchdog ends a hang
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datI <= d;
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        rd = datO;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clock);
        chk(ack, 1'b0, "ack drops");
    endtask : wb

    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task setMode(input hv_meas_pkg::mode_t m);
        @(posedge clock);
        devMode <= m;
        tick(2);
    endtask : setMode

    task finish_test;
        $display("checks %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task tReset;
        wb(hv_meas_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0, "ctrl reset");
        chk({swClose, pulls}, 5'h00, "switch/pulls reset");
        wb(8'h40, 1'b0, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        $display("test reset done");
    endtask : tReset

    // Enable refused while the pin is the fail output
    task tRefuse;
        wb(hv_meas_pkg::OFS_CTRL, 1'b1, 32'h04);
        wb(hv_meas_pkg::OFS_CTRL, 1'b1, 32'h05);
        wb(hv_meas_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h04, "enable refused");
        wb(hv_meas_pkg::OFS_IRQST, 1'b0, 32'h0);
        chk(rd, 32'h1, "refusal error");
        wb(hv_meas_pkg::OFS_IRQST, 1'b1, 32'h7);
        wb(hv_meas_pkg::OFS_CTRL, 1'b1, 32'h00);
        $display("test refuse done");
    endtask : tRefuse

    task tMeasure;
        wb(hv_meas_pkg::OFS_PULL, 1'b1, 32'hF);
        wb(hv_meas_pkg::OFS_CTRL, 1'b1, 32'h01);
        tick(1);
        chk(swClose, 1'b1, "switch closed");
        chk({pulls, gated}, 6'h00, "pulls off, gated");
        wb(hv_meas_pkg::OFS_PULL, 1'b0, 32'h0);
        chk(rd, 32'hF, "pull stored");
        hvSense <= ~hvSense;
        tick(10);
        chk({wakeEv, gated}, 4'h0, "inputs gated");
        chk({adcCode, pinLevel}, 9'h1FF, "sense routed");
        wb(hv_meas_pkg::OFS_IRQST, 1'b0, 32'h0);
        chk(rd, 32'h0, "status frozen");
        wb(hv_meas_pkg::OFS_CTRL, 1'b1, 32'h25);
        wb(hv_meas_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h21, "pin config kept");
        chk({pinOe, irq}, 2'b00, "no drive, masked");
        wb(hv_meas_pkg::OFS_IRQMSK, 1'b1, 32'h1);
        tick(1);
        chk(irq, 1'b1, "error irq");
        wb(hv_meas_pkg::OFS_IRQST, 1'b1, 32'h1);
        tick(1);
        chk(irq, 1'b0, "irq cleared");
        $display("test measure done");
    endtask : tMeasure

    // Switch follows mode, enable is retained
    task tModes;
        for (int i = 1; i < 5; i++) begin
            setMode(hv_meas_pkg::mode_t'(3'(i)));
            chk(swClose, 1'b0, "switch open off Normal");
            wb(hv_meas_pkg::OFS_CTRL, 1'b0, 32'h0);
            chk(rd, 32'h21, "enable kept");
            setMode(hv_meas_pkg::MODE_NORMAL);
            chk(swClose, 1'b1, "switch back");
        end
        $display("test modes done");
    endtask : tModes

    task sleepTry(input logic other, input logic [1:0] exp);
        @(posedge clock);
        otherWake <= other;
        sleepCmd <= 1'b1;
        @(posedge clock);
        sleepCmd <= 1'b0;
        #1;
        chk({rReq, sGrant}, exp, "sleep answer");
    endtask : sleepTry

    task tSleep;
        wb(hv_meas_pkg::OFS_CTRL, 1'b1, 32'h03);
        wb(hv_meas_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h03, "wake enable stored");
        sleepTry(1'b0, 2'b10);
        wb(hv_meas_pkg::OFS_IRQST, 1'b0, 32'h0);
        chk(rd, 32'h1, "sleep error");
        sleepTry(1'b1, 2'b01);
        $display("test sleep done");
    endtask : tSleep

    // Fail-Safe makes the sense input wake without its enable
    task tWake;
        wb(hv_meas_pkg::OFS_CTRL, 1'b1, 32'h00);
        wb(hv_meas_pkg::OFS_CTRL, 1'b1, 32'h08);
        setMode(hv_meas_pkg::MODE_FAILSAFE);
        tick(10);
        wb(hv_meas_pkg::OFS_IRQST, 1'b1, 32'h7);
        hvSense <= ~hvSense;
        // Pin pull-up dropped, leaving the pull-down, so the pin falls
        wb(hv_meas_pkg::OFS_PULL, 1'b1, 32'h4);
        tick(10);
        wb(hv_meas_pkg::OFS_IRQST, 1'b0, 32'h0);
        chk(rd[2:0], 3'h6, "fail-safe sense and pin wake");
        wb(hv_meas_pkg::OFS_LEVEL, 1'b0, 32'h0);
        chk(rd, 32'h0, "levels follow pins");
        setMode(hv_meas_pkg::MODE_NORMAL);
        $display("test wake done");
    endtask : tWake

    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        tReset;
        tRefuse;
        tMeasure;
        tModes;
        tSleep;
        tWake;
        finish_test;
    end

    // Whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        finish_test;
    end
endmodule : tb_hv_measure_path_control
